// ===== verilog/obcd_top.sv
// Configuration byte store, protection control and settings decoder
// Operation
// - Range field picks resonator range or external clock when internal RC is off.
// - Sector field sets boot sector zero to 0.5k, 1k, 2k or 4k.
// - Read-out protection blocks memory extraction and program flash writes.
// - Erasing bytes under read-out protection first erases whole program memory.
// - Write lock refuses program memory erase or write and its own clearing.
// - Configuration bytes are read or changed only in programming mode.
// - Multiplier factor bit selects times four or times eight.
// - Main multiplier bypass bit: zero enables, one bypasses.
// - Fast multiplier bypass bit: zero enables, one bypasses.
// - Clock source bit: zero internal RC on, one resonator or external.
// - Undervoltage field: 11 off, 10 highest, 01 medium, 00 lowest.
// - Watchdog type zero forces watchdog on; one leaves it to software.
// - Halt reset bit with active watchdog resets on halt entry.
// - Erased bytes read all ones; the user configures explicitly.
`timescale 1ns/1ps
module obcd_top
	import obcd_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [OBCD_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic prog_mode,
	input wire logic [7:0] nv_low,
	input wire logic [7:0] nv_high,
	output logic nv_commit,
	output logic [7:0] nv_commit_low,
	output logic [7:0] nv_commit_high,
	output logic pm_erase_req,
	input wire logic pm_erase_done,
	input wire logic halt_entry,
	input wire logic sw_wdg_enable,
	output logic halt_reset,
	output obcd_settings_t settings
);
	obcd_state_t st;
	obcd_state_t next_st;
	obcd_settings_t dec_settings;
	logic busy;
	logic wdg_active;
	logic erase_go;

	// Decoder sees the nonvolatile bytes; only sampled in the load phase
	obcd_decode u_decode (
		.byte_low(nv_low),
		.byte_high(nv_high),
		.settings(dec_settings)
	);

	assign busy = st.phase != PH_RUN;
	assign wdg_active = !st.settings.watchdog_type_select || sw_wdg_enable;
	assign erase_go = reg_wr && reg_addr == OBCD_REG_CTRL && reg_wdata[OBCD_CTRL_ERASE]
		&& prog_mode && !busy && !st.stored_low[OBCD_WLK_BIT];

	always_comb
	begin
		next_st = st;
		next_st.nv_commit = 1'b0;
		next_st.rdata = '0;
		next_st.halt_reset = halt_entry && wdg_active
			&& st.settings.halt_entry_reset_enable;
		unique case (st.phase)
			PH_LOAD:
			begin
				// Captured once per reset; later byte writes do not move settings
				next_st.stored_low = nv_low;
				next_st.stored_high = nv_high;
				next_st.settings = dec_settings;
				next_st.phase = PH_RUN;
			end
			PH_RUN:
			begin
			end
			PH_MASS:
			begin
				if (pm_erase_done)
				begin
					next_st.pm_erase_req = 1'b0;
					next_st.phase = PH_OPT;
				end
			end
			PH_OPT:
			begin
				next_st.stored_low = OBCD_ERASED;
				next_st.stored_high = OBCD_ERASED;
				next_st.nv_commit = 1'b1;
				next_st.phase = PH_RUN;
			end
		endcase
		// Clear first so that a refusal in the same cycle still sticks
		if (reg_wr && reg_addr == OBCD_REG_STAT && reg_wdata[OBCD_STAT_REFUSED])
			next_st.refused = 1'b0;
		if (reg_wr)
		begin
			unique case (reg_addr)
				OBCD_REG_LOW:
				begin
					if (!prog_mode || busy)
						next_st.refused = 1'b1;
					else
					begin
						next_st.stored_low = reg_wdata;
						// A set write lock can never be cleared again
						if (st.stored_low[OBCD_WLK_BIT])
							next_st.stored_low[OBCD_WLK_BIT] = 1'b1;
						next_st.nv_commit = 1'b1;
					end
				end
				OBCD_REG_HIGH:
				begin
					if (!prog_mode || busy)
						next_st.refused = 1'b1;
					else
					begin
						next_st.stored_high = reg_wdata;
						next_st.nv_commit = 1'b1;
					end
				end
				OBCD_REG_CTRL:
				begin
					if (reg_wdata[OBCD_CTRL_ERASE])
					begin
						if (!erase_go)
							next_st.refused = 1'b1;
						else if (st.stored_low[OBCD_RDP_BIT])
						begin
							next_st.pm_erase_req = 1'b1;
							next_st.phase = PH_MASS;
						end
						else
							next_st.phase = PH_OPT;
					end
				end
				default:
				begin
				end
			endcase
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				OBCD_REG_LOW: next_st.rdata = prog_mode ? st.stored_low : 8'h00;
				OBCD_REG_HIGH: next_st.rdata = prog_mode ? st.stored_high : 8'h00;
				OBCD_REG_STAT:
				begin
					next_st.rdata[OBCD_STAT_BUSY] = busy;
					next_st.rdata[OBCD_STAT_REFUSED] = st.refused;
					next_st.rdata[OBCD_STAT_PROG] = prog_mode;
				end
				default: next_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			st <= '0;
			st.phase <= PH_LOAD;
			st.stored_low <= OBCD_SETTINGS_RST_BYTE;
			st.stored_high <= OBCD_SETTINGS_RST_BYTE;
		end
		else
			st <= next_st;
	end

	assign reg_rdata = st.rdata;
	assign nv_commit = st.nv_commit;
	assign nv_commit_low = st.stored_low;
	assign nv_commit_high = st.stored_high;
	assign pm_erase_req = st.pm_erase_req;
	assign halt_reset = st.halt_reset;
	assign settings = st.settings;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	AST_INTERNAL_RC: assert property (
		st.phase == PH_LOAD && !nv_high[OBCD_RC_OFF_BIT]
		|=> settings.clk_src == CLK_INTERNAL_RC && settings.rc_enable)
		else $error("internal RC not selected after load");
	AST_RANGE_VLP: assert property (
		st.phase == PH_LOAD && nv_high[OBCD_RC_OFF_BIT]
		&& nv_low[OBCD_RANGE_LSB +: 3] == OBCD_RANGE_VLP
		|=> settings.clk_src == CLK_VERY_LOW_POWER_RANGE)
		else $error("range code not decoded");
	AST_SECTOR: assert property (
		st.phase == PH_LOAD && nv_low[OBCD_SEC_LSB +: 2] == 2'h3
		|=> settings.boot_sector_size == OBCD_SEC_BLOCKS_3)
		else $error("sector size wrong");
	AST_PROTECT: assert property (
		settings.readout_protect |-> settings.flash_read_block && settings.flash_write_block)
		else $error("read-out protection not blocking");
	AST_MASS_FIRST: assert property (
		erase_go && st.stored_low[OBCD_RDP_BIT]
		|=> pm_erase_req && st.stored_low == $past(st.stored_low) throughout pm_erase_req [*1])
		else $error("mass erase not started first");
	AST_LOCK_REFUSE: assert property (
		reg_wr && reg_addr == OBCD_REG_CTRL && reg_wdata[OBCD_CTRL_ERASE]
		&& st.stored_low[OBCD_WLK_BIT]
		|=> !pm_erase_req && st.refused && st.stored_low[OBCD_WLK_BIT] [*2])
		else $error("locked erase was not refused");
	AST_READ_GATE: assert property (
		reg_rd && !prog_mode && (reg_addr == OBCD_REG_LOW || reg_addr == OBCD_REG_HIGH)
		|=> reg_rdata == 8'h00)
		else $error("configuration read outside programming mode");
	AST_HALT_RESET: assert property (
		halt_entry && !settings.watchdog_type_select && settings.halt_entry_reset_enable
		|=> halt_reset)
		else $error("halt entry reset missing");
	AST_NO_HALT_RESET: assert property (
		halt_entry && !settings.halt_entry_reset_enable |=> !halt_reset)
		else $error("unexpected halt reset");
	AST_ERASED: assert property (
		st.phase == PH_OPT |=> st.stored_low == OBCD_ERASED && st.stored_high == OBCD_ERASED
		&& nv_commit)
		else $error("erase did not leave all ones");
	AST_HOLD: assert property (
		st.phase != PH_LOAD |=> $stable(settings))
		else $error("settings moved after load");
	AST_CLOCK_MULT: assert property (
		st.phase == PH_LOAD
		|=> settings.multiplier_factor_select == $past(nv_high[OBCD_MUL_BIT])
		&& settings.main_multiplier_bypass == $past(nv_high[OBCD_MAIN_BYP_BIT])
		&& settings.fast_multiplier_bypass == $past(nv_high[OBCD_FAST_BYP_BIT]))
		else $error("multiplier settings not decoded");
	AST_UNDERVOLT_OFF: assert property (
		st.phase == PH_LOAD && nv_high[OBCD_UV_LSB +: 2] == 2'h3
		|=> !settings.undervoltage_enable && settings.undervoltage_threshold_select == UV_OFF)
		else $error("undervoltage detector not off");
	AST_WDG_FORCED: assert property (
		st.phase == PH_LOAD && !nv_high[OBCD_WDT_BIT] |=> settings.watchdog_forced_on)
		else $error("hardware watchdog not forced on");
	// Read data stands one cycle only, so stale bytes never leak
	AST_RDATA_IDLE: assert property (
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	AST_WRITE_GATE: assert property (
		reg_wr && !prog_mode && (reg_addr == OBCD_REG_LOW || reg_addr == OBCD_REG_HIGH)
		|=> !nv_commit && st.refused)
		else $error("configuration write outside programming mode");
	AST_LOCK_KEEP: assert property (
		st.phase == PH_RUN && st.stored_low[OBCD_WLK_BIT] |=> st.stored_low[OBCD_WLK_BIT])
		else $error("write lock cleared");

	COV_MASS: cover property (erase_go && st.stored_low[OBCD_RDP_BIT] ##[1:50] st.phase == PH_OPT);
	COV_PLAIN_ERASE: cover property (erase_go && !st.stored_low[OBCD_RDP_BIT] ##2 nv_commit);
	COV_WRITE: cover property (reg_wr && prog_mode && reg_addr == OBCD_REG_HIGH ##1 nv_commit);
	COV_HALT: cover property (halt_reset);
	COV_REFUSED: cover property (reg_wr && !prog_mode ##1 st.refused);
endmodule : obcd_top

// ===== include/obcd_pkg.sv
// Shared types and constants for the configuration byte decoder
package obcd_pkg;
	localparam int OBCD_ADDR_W = 4;
	localparam logic [3:0] OBCD_REG_LOW = 4'h0;
	localparam logic [3:0] OBCD_REG_HIGH = 4'h4;
	localparam logic [3:0] OBCD_REG_CTRL = 4'h8;
	localparam logic [3:0] OBCD_REG_STAT = 4'hC;
	localparam logic [7:0] OBCD_ERASED = 8'hFF;
	localparam logic [7:0] OBCD_SETTINGS_RST_BYTE = 8'hFF;
	// Low byte layout
	localparam int OBCD_RES_BIT = 7;
	localparam int OBCD_RANGE_LSB = 4;
	localparam int OBCD_SEC_LSB = 2;
	localparam int OBCD_RDP_BIT = 1;
	localparam int OBCD_WLK_BIT = 0;
	// High byte layout
	localparam int OBCD_MUL_BIT = 7;
	localparam int OBCD_MAIN_BYP_BIT = 6;
	localparam int OBCD_FAST_BYP_BIT = 5;
	localparam int OBCD_RC_OFF_BIT = 4;
	localparam int OBCD_UV_LSB = 2;
	localparam int OBCD_WDT_BIT = 1;
	localparam int OBCD_HALT_BIT = 0;
	// Control and status bits
	localparam int OBCD_CTRL_ERASE = 0;
	localparam int OBCD_STAT_BUSY = 0;
	localparam int OBCD_STAT_REFUSED = 1;
	localparam int OBCD_STAT_PROG = 2;
	// Range codes
	localparam logic [2:0] OBCD_RANGE_LOW = 3'h0;
	localparam logic [2:0] OBCD_RANGE_MID = 3'h1;
	localparam logic [2:0] OBCD_RANGE_MIDHI = 3'h2;
	localparam logic [2:0] OBCD_RANGE_HIGH = 3'h3;
	localparam logic [2:0] OBCD_RANGE_VLP = 3'h4;
	localparam logic [2:0] OBCD_RANGE_EXT_RES = 3'h5;
	localparam logic [2:0] OBCD_RANGE_RSVD = 3'h6;
	localparam logic [2:0] OBCD_RANGE_EXT_PIN = 3'h7;
	// Sector zero size in 512-byte blocks
	localparam logic [3:0] OBCD_SEC_BLOCKS_0 = 4'h1;
	localparam logic [3:0] OBCD_SEC_BLOCKS_1 = 4'h2;
	localparam logic [3:0] OBCD_SEC_BLOCKS_2 = 4'h4;
	localparam logic [3:0] OBCD_SEC_BLOCKS_3 = 4'h8;

	typedef enum logic [3:0] {
		CLK_LOW_FREQUENCY_RANGE, CLK_MID_FREQUENCY_RANGE, CLK_MID_HIGH_RANGE,
		CLK_HIGH_SPEED_RANGE, CLK_VERY_LOW_POWER_RANGE, CLK_EXT_ON_RESONATOR_PIN_ONE,
		CLK_EXT_ON_PORT_PIN, CLK_RESERVED, CLK_INTERNAL_RC
	} obcd_clk_t;

	typedef enum logic [1:0] {UV_LOWEST, UV_MEDIUM, UV_HIGHEST, UV_OFF} obcd_uv_t;

	typedef enum logic [1:0] {PH_LOAD, PH_RUN, PH_MASS, PH_OPT} obcd_phase_t;

	typedef struct packed {
		obcd_clk_t clk_src;
		logic [2:0] clock_range_select;
		logic rc_enable;
		logic multiplier_factor_select;
		logic main_multiplier_bypass;
		logic fast_multiplier_bypass;
		logic [3:0] boot_sector_size;
		logic readout_protect;
		logic program_write_lock;
		logic flash_read_block;
		logic flash_write_block;
		logic undervoltage_enable;
		obcd_uv_t undervoltage_threshold_select;
		logic watchdog_type_select;
		logic watchdog_forced_on;
		logic halt_entry_reset_enable;
	} obcd_settings_t;

	typedef struct packed {
		obcd_phase_t phase;
		logic [7:0] stored_low;
		logic [7:0] stored_high;
		obcd_settings_t settings;
		logic refused;
		logic pm_erase_req;
		logic halt_reset;
		logic nv_commit;
		logic [7:0] rdata;
	} obcd_state_t;
endpackage : obcd_pkg

// ===== verilog/obcd_decode.sv
// Combinational decode of the two configuration bytes into settings
`timescale 1ns/1ps
module obcd_decode
	import obcd_pkg::*;
(
	input wire logic [7:0] byte_low,
	input wire logic [7:0] byte_high,
	output obcd_settings_t settings
);
	logic [2:0] range;
	logic [1:0] sec;

	always_comb
	begin
		range = byte_low[OBCD_RANGE_LSB +: 3];
		sec = byte_low[OBCD_SEC_LSB +: 2];
		settings = '0;
		settings.clock_range_select = range;
		settings.rc_enable = !byte_high[OBCD_RC_OFF_BIT];
		if (settings.rc_enable)
			settings.clk_src = CLK_INTERNAL_RC;
		else
		begin
			unique case (range)
				OBCD_RANGE_LOW: settings.clk_src = CLK_LOW_FREQUENCY_RANGE;
				OBCD_RANGE_MID: settings.clk_src = CLK_MID_FREQUENCY_RANGE;
				OBCD_RANGE_MIDHI: settings.clk_src = CLK_MID_HIGH_RANGE;
				OBCD_RANGE_HIGH: settings.clk_src = CLK_HIGH_SPEED_RANGE;
				OBCD_RANGE_VLP: settings.clk_src = CLK_VERY_LOW_POWER_RANGE;
				OBCD_RANGE_EXT_RES: settings.clk_src = CLK_EXT_ON_RESONATOR_PIN_ONE;
				OBCD_RANGE_EXT_PIN: settings.clk_src = CLK_EXT_ON_PORT_PIN;
				OBCD_RANGE_RSVD: settings.clk_src = CLK_RESERVED;
			endcase
		end
		unique case (sec)
			2'h0: settings.boot_sector_size = OBCD_SEC_BLOCKS_0;
			2'h1: settings.boot_sector_size = OBCD_SEC_BLOCKS_1;
			2'h2: settings.boot_sector_size = OBCD_SEC_BLOCKS_2;
			2'h3: settings.boot_sector_size = OBCD_SEC_BLOCKS_3;
		endcase
		settings.readout_protect = byte_low[OBCD_RDP_BIT];
		settings.program_write_lock = byte_low[OBCD_WLK_BIT];
		settings.flash_read_block = byte_low[OBCD_RDP_BIT];
		// Read-out protection also blocks program writes
		settings.flash_write_block = byte_low[OBCD_RDP_BIT] | byte_low[OBCD_WLK_BIT];
		settings.multiplier_factor_select = byte_high[OBCD_MUL_BIT];
		settings.main_multiplier_bypass = byte_high[OBCD_MAIN_BYP_BIT];
		settings.fast_multiplier_bypass = byte_high[OBCD_FAST_BYP_BIT];
		settings.undervoltage_threshold_select = obcd_uv_t'(byte_high[OBCD_UV_LSB +: 2]);
		settings.undervoltage_enable = byte_high[OBCD_UV_LSB +: 2] != 2'h3;
		settings.watchdog_type_select = byte_high[OBCD_WDT_BIT];
		settings.watchdog_forced_on = !byte_high[OBCD_WDT_BIT];
		settings.halt_entry_reset_enable = byte_high[OBCD_HALT_BIT];
	end
endmodule : obcd_decode

// ===== test/obcd_nv_model.sv
// Nonvolatile byte store and program memory eraser facing the decoder
`timescale 1ns/1ps
module obcd_nv_model (
	input wire logic clock,
	input wire logic rstn,
	input wire logic slow,
	input wire logic ld,
	input wire logic [7:0] ld_low,
	input wire logic [7:0] ld_high,
	input wire logic nv_commit,
	input wire logic [7:0] nv_commit_low,
	input wire logic [7:0] nv_commit_high,
	input wire logic pm_erase_req,
	output logic pm_erase_done,
	output logic [7:0] nv_low,
	output logic [7:0] nv_high
);
	logic [3:0] wait_cnt;
	logic served;
	// Store survives reset, as the real cells do
	always @(posedge clock)
	begin
		if (ld)
		begin
			nv_low <= ld_low;
			nv_high <= ld_high;
		end
		else if (nv_commit)
		begin
			nv_low <= nv_commit_low;
			nv_high <= nv_commit_high;
		end
	end
	// Slow mode stretches the erase so busy can be seen; one answer per request
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn || !pm_erase_req)
		begin
			wait_cnt <= 4'h0;
			served <= 1'b0;
			pm_erase_done <= 1'b0;
		end
		else if (served)
			pm_erase_done <= 1'b0;
		else if (wait_cnt == (slow ? 4'h6 : 4'h0))
		begin
			pm_erase_done <= 1'b1;
			served <= 1'b1;
		end
		else
			wait_cnt <= wait_cnt + 4'h1;
	end
endmodule : obcd_nv_model

// ===== test/tb_top.sv
// Self-checking bench for the configuration byte decoder
`timescale 1ns/1ps
module tb_top
	import obcd_pkg::*;
;
	logic clock = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, prog_mode = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, nv_low, nv_high, nv_commit_low, nv_commit_high;
	logic nv_commit, pm_erase_req, pm_erase_done, halt_reset, rd_pend = 1'b0, hr_pend = 1'b0;
	logic halt_entry = 1'b0, sw_wdg_enable = 1'b0, slow = 1'b1, ld = 1'b0;
	logic [7:0] ld_low = 8'hFF, ld_high = 8'hFF, lo, hi;
	obcd_settings_t settings;
	logic [7:0] rq[$];
	logic [15:0] cq[$];
	logic hq[$];
	int n_mismatch = 0, num_checks = 0, seed = 38681, r;
	obcd_clk_t cmap [8] = '{CLK_LOW_FREQUENCY_RANGE, CLK_MID_FREQUENCY_RANGE,
		CLK_MID_HIGH_RANGE, CLK_HIGH_SPEED_RANGE, CLK_VERY_LOW_POWER_RANGE,
		CLK_EXT_ON_RESONATOR_PIN_ONE, CLK_RESERVED, CLK_EXT_ON_PORT_PIN};
	always #12.5 clock = ~clock;
	obcd_top i_dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_mode(prog_mode),
		.nv_low(nv_low), .nv_high(nv_high), .nv_commit(nv_commit),
		.nv_commit_low(nv_commit_low), .nv_commit_high(nv_commit_high),
		.pm_erase_req(pm_erase_req), .pm_erase_done(pm_erase_done), .halt_entry(halt_entry),
		.sw_wdg_enable(sw_wdg_enable), .halt_reset(halt_reset), .settings(settings));
	obcd_nv_model i_nv (.clock(clock), .rstn(rstn), .slow(slow), .ld(ld), .ld_low(ld_low),
		.ld_high(ld_high), .nv_commit(nv_commit), .nv_commit_low(nv_commit_low),
		.nv_commit_high(nv_commit_high), .pm_erase_req(pm_erase_req),
		.pm_erase_done(pm_erase_done), .nv_low(nv_low), .nv_high(nv_high));
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task results;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	function automatic obcd_settings_t exp_set(input logic [7:0] l, input logic [7:0] h);
		obcd_settings_t s;
		s = '0;
		s.clk_src = h[4] ? cmap[l[6:4]] : CLK_INTERNAL_RC;
		s.clock_range_select = l[6:4];
		s.rc_enable = ~h[4];
		{s.multiplier_factor_select, s.main_multiplier_bypass, s.fast_multiplier_bypass} = h[7:5];
		s.boot_sector_size = 4'h1 << l[3:2];
		{s.readout_protect, s.program_write_lock} = l[1:0];
		s.flash_read_block = l[1];
		s.flash_write_block = l[1] | l[0];
		s.undervoltage_enable = h[3:2] != 2'h3;
		s.undervoltage_threshold_select = obcd_uv_t'(h[3:2]);
		s.watchdog_type_select = h[1];
		s.watchdog_forced_on = ~h[1];
		s.halt_entry_reset_enable = h[0];
		return s;
	endfunction : exp_set
	// Scoreboard: results are taken off the queues as they show at the ports
	always @(posedge clock)
	begin
		if (rd_pend)
			check("rdata", reg_rdata, rq.size() ? rq.pop_front() : 8'hXX);
		if (nv_commit)
			check("commit", {nv_commit_low, nv_commit_high}, cq.size() ? cq.pop_front() : 16'hXXXX);
		if (hr_pend || halt_reset)
			check("halt_reset", halt_reset, hr_pend ? hq.pop_front() : 1'b0);
		rd_pend <= reg_rd;
		hr_pend <= halt_entry;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rq.push_back(e);
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask : rd
	task automatic halt(input logic sw, input logic e);
		@(posedge clock);
		sw_wdg_enable <= sw;
		halt_entry <= 1'b1;
		hq.push_back(e);
		@(posedge clock);
		halt_entry <= 1'b0;
	endtask : halt
	// Bytes come in through the store, then a reset captures them
	task automatic boot(input logic [7:0] l, input logic [7:0] h);
		@(posedge clock);
		{ld, ld_low, ld_high, rstn} <= {1'b1, l, h, 1'b0};
		@(posedge clock);
		ld <= 1'b0;
		@(posedge clock);
		#1 check("settings_rst", settings, 0);
		rstn <= 1'b1;
		repeat (3) @(posedge clock);
		#1 check("settings", settings, exp_set(l, h));
	endtask : boot
	task automatic drain;
		for (int i = 0; i < 100 && cq.size() != 0; i++)
			@(posedge clock);
		if (cq.size() != 0)
		begin
			n_mismatch++;
			results;
		end
	endtask : drain
	initial
	begin
		for (int i = 0; i < 10; i++)
		begin
			r = $random(seed);
			// Top bit of the low byte always one; range steps through all eight codes with RC off
			lo = (i < 8) ? {1'b1, 3'(i), r[3:0]} : (i == 8) ? {4'hF, r[3:0]} : 8'hFF;
			hi = (i < 8) ? (r[15:8] | 8'h10) : (i == 8) ? (r[15:8] & 8'hEF) : 8'hFF;
			boot(lo, hi);
		end
		boot(8'hF2, 8'hE5);
		rd(4'h0, 8'h00);
		rd(4'h2, 8'h00);
		wr(4'h4, 8'h12);
		rd(4'hC, 8'h02);
		wr(4'hC, 8'h02);
		rd(4'hC, 8'h00);
		halt(1'b0, 1'b1);
		prog_mode <= 1'b1;
		rd(4'h0, 8'hF2);
		rd(4'h4, 8'hE5);
		cq.push_back(16'hF23F);
		wr(4'h4, 8'h3F);
		cq.push_back(16'hFFFF);
		wr(4'h8, 8'h01);
		#1 check("erase_req", pm_erase_req, 1'b1);
		rd(4'hC, 8'h05);
		drain();
		check("settings_hold", settings, exp_set(8'hF2, 8'hE5));
		rd(4'h0, 8'hFF);
		rd(4'hC, 8'h04);
		slow <= 1'b0;
		boot(8'hF1, 8'hFF);
		wr(4'h8, 8'h01);
		#1 check("erase_req_lock", pm_erase_req, 1'b0);
		rd(4'hC, 8'h06);
		cq.push_back(16'hF1FF);
		wr(4'h0, 8'hF0);
		drain();
		halt(1'b0, 1'b0);
		halt(1'b1, 1'b1);
		repeat (4) @(posedge clock);
		results;
	end
endmodule : tb_top
